// *** common/ramp_pkg.sv ***
package ramp_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_NDIV = 8'h04;
	localparam logic [7:0] OFS_NUM = 8'h08;
	localparam logic [7:0] OFS_DEN = 8'h0C;
	localparam logic [7:0] OFS_DEV_LO = 8'h10;
	localparam logic [7:0] OFS_DEV_HI = 8'h14;
	localparam logic [7:0] OFS_SW_CMD = 8'h18;
	localparam logic [7:0] OFS_TRIG_CFG = 8'h1C;
	localparam logic [7:0] OFS_RAMP_CNT = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h2C;
	localparam logic [7:0] OFS_IRQ_EN = 8'h30;
	// Segment table window: 0x40 + 8*segment, word 0 increment, word 1 config
	localparam logic [1:0] SEG_WIN = 2'h1;

	// Control fields
	localparam int CTRL_RAMP_EN = 0;
	localparam int CTRL_PHASE_SEL = 1;
	localparam int CTRL_KTRIG_LSB = 2;
	// Segment config fields
	localparam int SEG_LEN_LSB = 0;
	localparam int SEG_DBL = 16;
	localparam int SEG_ADV_LSB = 17;
	localparam int SEG_SUCC_LSB = 19;
	localparam int SEG_LOCK_LSB = 22;
	localparam int SEG_FLAG_LSB = 24;
	// Trigger config: 4 bits per trigger, pin select then edge select
	localparam int TRIG_FIELD_W = 4;
	// Interrupt bits
	localparam int IRQ_ADVANCE = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_KEYING = 2;

	// Reset values and the forced ramp denominator
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] NDIV_RST = 16'h0064;
	localparam logic [23:0] NUM_RST = 24'h00_0000;
	localparam logic [24:0] DEN_RST = 25'h100_0000;
	localparam logic [24:0] RAMP_DEN = 25'h100_0000;

	// Advance events and charge pump choices
	localparam logic [1:0] ADV_LENGTH = 2'h0;
	localparam logic [1:0] LOCK_ALT_CP = 2'h1;
	localparam logic [1:0] LOCK_ACCEL = 2'h2;
	localparam logic [2:0] KTRIG_SOFTWARE = 3'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE, ST_FETCH_INC, ST_FETCH_CFG, ST_LATCH, ST_RUN, ST_HOLD
	} eng_state_t;
endpackage : ramp_pkg

// *** core/segment_table.sv ***
`timescale 1ns/10ps
// Segment table with byte-lane writes and two registered read ports
module segment_table #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16,
	parameter int ADDR_W = 4
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [WIDTH/8-1:0] wr_strb,
	input wire logic [ADDR_W-1:0] rd_a_addr,
	output logic [WIDTH-1:0] rd_a_data,
	input wire logic [ADDR_W-1:0] rd_b_addr,
	output logic [WIDTH-1:0] rd_b_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Byte-lane write
	always_ff @(posedge clk) begin
		for (int i = 0; i < WIDTH / 8; i++) begin
			if (wr_en && wr_strb[i]) begin
				mem[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
			end
		end
	end

	// Registered reads
	always_ff @(posedge clk) begin
		rd_a_data <= mem[rd_a_addr];
		rd_b_data <= mem[rd_b_addr];
	end
endmodule : segment_table

// *** core/ramp_fsk_top.sv ***
`timescale 1ns/10ps
module ramp_fsk_top import ramp_pkg::*; #(
	parameter int INC_W = 30,
	parameter int CNT_W = 16
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic io_pin_one,
	input wire logic io_pin_two,
	input wire logic io_pin_three,
	input wire logic selectable_output_pin,
	output logic [15:0] div_int,
	output logic [23:0] div_frac,
	output logic [24:0] div_den,
	output logic [23:0] phase_offset,
	output logic keying_level,
	output logic cp_alt_current,
	output logic lock_accel_active,
	output logic [1:0] ramp_flag,
	output logic ramp_running,
	output logic irq
);
	// Merge written byte lanes into an old word
	function automatic logic [31:0] apply_strb(logic [31:0] old, logic [31:0] nw,
			logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : apply_strb

	// Segment table window decode
	function automatic logic in_seg_win(logic [7:0] a);
		return a[7:6] == SEG_WIN;
	endfunction : in_seg_win

	logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [7:0] aw_addr_ff, ar_addr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic arready_ff, ar_pend_ff, rvalid_ff;
	logic [31:0] ctrl_ff, dev_lo_ff, trig_cfg_ff;
	logic [15:0] ndiv_ff, ramp_cnt_ff;
	logic [23:0] num_ff;
	logic [24:0] den_ff;
	logic dev_hi_ff;
	logic [2:0] irq_stat_ff, irq_en_ff;
	logic [3:0] sw_pend_ff;
	logic restart_ff;
	logic [3:0] s1_ff, s2_ff, s3_ff, pin_ff;
	logic [3:0] pin_rise, pin_fall;
	eng_state_t state_ff;
	logic [2:0] seg_ff;
	logic [31:0] cfg_ff;
	logic [INC_W-1:0] inc_ff;
	logic [CNT_W-1:0] cnt_ff, pass_ff;
	logic half_ff;
	logic [39:0] acc_ff;
	logic level_ff;
	logic [15:0] div_int_ff;
	logic [23:0] div_frac_ff, phase_ff;
	logic [24:0] div_den_ff;
	logic cp_alt_ff, lock_acc_ff, running_ff, irq_ff;
	logic [1:0] flag_ff;
	logic [31:0] mem_a_data, mem_b_data;

	logic do_wr, ar_take, wr_seg, restart_req, step, len_reached, advance, ktrig;
	logic [2:0] trig_fire;
	logic [2:0] nxt_seg;
	logic [39:0] nxt_out;

	// Write channel capture, address and data in either order
	assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end else if (do_wr) begin
				aw_held_ff <= 1'b0;
			end
			if (s_axi_wvalid && wready_ff) begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (do_wr) begin
				w_held_ff <= 1'b0;
			end
			// Ready again only once the write response has been handed over
			awready_ff <= !aw_held_ff && !(bvalid_ff && !s_axi_bready)
				&& !(s_axi_awvalid && awready_ff);
			wready_ff <= !w_held_ff && !(bvalid_ff && !s_axi_bready)
				&& !(s_axi_wvalid && wready_ff);
		end
	end

	// Write response
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (aw_addr_ff <= OFS_IRQ_EN || in_seg_win(aw_addr_ff)) ?
				RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign wr_seg = do_wr && in_seg_win(aw_addr_ff);
	assign restart_req = do_wr && aw_addr_ff == OFS_NDIV && wstrb_ff[0];

	// Configuration registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_ff <= CTRL_RST;
			ndiv_ff <= NDIV_RST;
			num_ff <= NUM_RST;
			den_ff <= DEN_RST;
			dev_lo_ff <= 32'h0000_0000;
			dev_hi_ff <= 1'b0;
			trig_cfg_ff <= 32'h0000_0000;
			ramp_cnt_ff <= 16'h0000;
			irq_en_ff <= 3'h0;
		end else if (do_wr) begin
			if (aw_addr_ff == OFS_CTRL) begin
				ctrl_ff <= apply_strb(ctrl_ff, wdata_ff, wstrb_ff);
			end else if (aw_addr_ff == OFS_NDIV) begin
				ndiv_ff <= 16'(apply_strb({16'h0000, ndiv_ff}, wdata_ff, wstrb_ff));
			end else if (aw_addr_ff == OFS_NUM) begin
				num_ff <= 24'(apply_strb({8'h00, num_ff}, wdata_ff, wstrb_ff));
			end else if (aw_addr_ff == OFS_DEN) begin
				den_ff <= 25'(apply_strb({7'h00, den_ff}, wdata_ff, wstrb_ff));
			end else if (aw_addr_ff == OFS_DEV_LO) begin
				dev_lo_ff <= apply_strb(dev_lo_ff, wdata_ff, wstrb_ff);
			end else if (aw_addr_ff == OFS_DEV_HI) begin
				if (wstrb_ff[0]) dev_hi_ff <= wdata_ff[0];
			end else if (aw_addr_ff == OFS_TRIG_CFG) begin
				trig_cfg_ff <= apply_strb(trig_cfg_ff, wdata_ff, wstrb_ff);
			end else if (aw_addr_ff == OFS_RAMP_CNT) begin
				ramp_cnt_ff <= 16'(apply_strb({16'h0000, ramp_cnt_ff}, wdata_ff, wstrb_ff));
			end else if (aw_addr_ff == OFS_IRQ_EN) begin
				irq_en_ff <= 3'(apply_strb({29'h0, irq_en_ff}, wdata_ff, wstrb_ff));
			end
		end
	end

	// Software triggers pend until the next detector cycle (clk_en high)
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sw_pend_ff <= 4'h0;
			restart_ff <= 1'b0;
		end else begin
			sw_pend_ff <= (sw_pend_ff & {4{!clk_en}}) |
				((do_wr && aw_addr_ff == OFS_SW_CMD && wstrb_ff[0]) ? wdata_ff[3:0] : 4'h0);
			restart_ff <= restart_req || (restart_ff && !clk_en);
		end
	end

	// Read channel: address taken, data on the next edge
	assign ar_take = s_axi_arvalid && arready_ff;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			arready_ff <= 1'b0;
			ar_pend_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			ar_addr_ff <= 8'h00;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end else begin
			arready_ff <= !ar_take && !ar_pend_ff && (!rvalid_ff || s_axi_rready);
			ar_pend_ff <= ar_take;
			if (ar_take) ar_addr_ff <= s_axi_araddr;
			if (ar_pend_ff) begin
				rvalid_ff <= 1'b1;
				rresp_ff <= RESP_OKAY;
				if (in_seg_win(ar_addr_ff)) rdata_ff <= mem_a_data;
				else if (ar_addr_ff == OFS_CTRL) rdata_ff <= ctrl_ff;
				else if (ar_addr_ff == OFS_NDIV) rdata_ff <= {16'h0000, ndiv_ff};
				else if (ar_addr_ff == OFS_NUM) rdata_ff <= {8'h00, num_ff};
				else if (ar_addr_ff == OFS_DEN) rdata_ff <= {7'h00, den_ff};
				else if (ar_addr_ff == OFS_DEV_LO) rdata_ff <= dev_lo_ff;
				else if (ar_addr_ff == OFS_DEV_HI) rdata_ff <= {31'h0, dev_hi_ff};
				else if (ar_addr_ff == OFS_TRIG_CFG) rdata_ff <= trig_cfg_ff;
				else if (ar_addr_ff == OFS_RAMP_CNT) rdata_ff <= {16'h0000, ramp_cnt_ff};
				else if (ar_addr_ff == OFS_STATUS) begin
					rdata_ff <= {pass_ff, 11'h0, level_ff, running_ff, seg_ff};
				end else if (ar_addr_ff == OFS_IRQ_STAT) rdata_ff <= {29'h0, irq_stat_ff};
				else if (ar_addr_ff == OFS_IRQ_EN) rdata_ff <= {29'h0, irq_en_ff};
				else if (ar_addr_ff == OFS_SW_CMD || ar_addr_ff == OFS_IRQ_CLR) begin
					rdata_ff <= 32'h0000_0000;
				end else begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// Segment storage, port a for bus reads, port b for the engine
	segment_table #(.WIDTH(32), .DEPTH(16), .ADDR_W(4)) u_table (
		.clk(sys_clk),
		.wr_en(wr_seg),
		.wr_addr(aw_addr_ff[5:2]),
		.wr_data(wdata_ff),
		.wr_strb(wstrb_ff),
		.rd_a_addr(s_axi_araddr[5:2]),
		.rd_a_data(mem_a_data),
		.rd_b_addr({seg_ff, state_ff != ST_FETCH_INC}),
		.rd_b_data(mem_b_data)
	);

	// Pin synchronisers, edge counted once second and third stages agree
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_ff <= 4'h0;
			s2_ff <= 4'h0;
			s3_ff <= 4'h0;
			pin_ff <= 4'h0;
		end else if (clk_en) begin
			s1_ff <= {selectable_output_pin, io_pin_three, io_pin_two, io_pin_one};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (int i = 0; i < 4; i++) begin
				if (s2_ff[i] == s3_ff[i]) pin_ff[i] <= s3_ff[i];
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_rise[i] = s2_ff[i] && s3_ff[i] && !pin_ff[i];
			pin_fall[i] = !s2_ff[i] && !s3_ff[i] && pin_ff[i];
		end
	end

	// Triggers A, B, C: pin select plus rise/fall enables, or software
	always_comb begin
		for (int t = 0; t < 3; t++) begin
			trig_fire[t] = clk_en && (sw_pend_ff[t+1]
				|| (trig_cfg_ff[t*TRIG_FIELD_W+2] && pin_rise[trig_cfg_ff[t*TRIG_FIELD_W +: 2]])
				|| (trig_cfg_ff[t*TRIG_FIELD_W+3] && pin_fall[trig_cfg_ff[t*TRIG_FIELD_W +: 2]]));
		end
	end

	// Keying trigger: software or any transition on the chosen pin
	always_comb begin
		ktrig = 1'b0;
		if (ctrl_ff[CTRL_KTRIG_LSB +: 3] == KTRIG_SOFTWARE) begin
			ktrig = clk_en && sw_pend_ff[0];
		end else if (ctrl_ff[CTRL_KTRIG_LSB +: 3] <= 3'h4) begin
			ktrig = clk_en && (pin_rise[ctrl_ff[CTRL_KTRIG_LSB +: 2] - 2'h1]
				|| pin_fall[ctrl_ff[CTRL_KTRIG_LSB +: 2] - 2'h1]);
		end
	end

	// Two-level keying toggles on each trigger
	always_ff @(posedge sys_clk) begin
		if (srst) level_ff <= 1'b0;
		else if (ktrig) level_ff <= !level_ff;
	end

	// Step and advance decisions for the running segment
	assign step = !cfg_ff[SEG_DBL] || half_ff;
	assign len_reached = cnt_ff >= cfg_ff[SEG_LEN_LSB +: CNT_W];
	assign nxt_seg = cfg_ff[SEG_SUCC_LSB +: 3];
	always_comb begin
		if (cfg_ff[SEG_ADV_LSB +: 2] == ADV_LENGTH) advance = len_reached;
		else advance = trig_fire[cfg_ff[SEG_ADV_LSB +: 2] - 2'h1];
	end

	// Ramp engine
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			seg_ff <= 3'h0;
			cfg_ff <= 32'h0000_0000;
			inc_ff <= '0;
			cnt_ff <= '0;
			pass_ff <= '0;
			half_ff <= 1'b0;
			acc_ff <= {NDIV_RST, NUM_RST};
		end else if (clk_en) begin
			if (!ctrl_ff[CTRL_RAMP_EN] || restart_ff) begin
				state_ff <= ctrl_ff[CTRL_RAMP_EN] ? ST_FETCH_INC : ST_IDLE;
				seg_ff <= 3'h0;
				pass_ff <= '0;
				acc_ff <= {ndiv_ff, num_ff};
			end else begin
				case (state_ff)
					ST_IDLE: state_ff <= ST_IDLE;
					ST_FETCH_INC: state_ff <= ST_FETCH_CFG;
					ST_FETCH_CFG: begin
						inc_ff <= mem_b_data[INC_W-1:0];
						state_ff <= ST_LATCH;
					end
					ST_LATCH: begin
						cfg_ff <= mem_b_data;
						cnt_ff <= '0;
						half_ff <= 1'b0;
						state_ff <= ST_RUN;
					end
					ST_RUN: begin
						half_ff <= cfg_ff[SEG_DBL] && !half_ff;
						if (step && !len_reached) begin
							acc_ff <= acc_ff + {{(40-INC_W){inc_ff[INC_W-1]}}, inc_ff};
							cnt_ff <= cnt_ff + 1'b1;
						end
						if (advance) begin
							seg_ff <= nxt_seg;
							if (nxt_seg == 3'h0) pass_ff <= pass_ff + 1'b1;
							if (nxt_seg == 3'h0 && ramp_cnt_ff != '0
									&& pass_ff + 1'b1 == ramp_cnt_ff) begin
								state_ff <= ST_HOLD;
							end else begin
								state_ff <= ST_FETCH_INC;
							end
						end
					end
					default: state_ff <= ST_HOLD;
				endcase
			end
		end
	end

	// Divider value with keying deviation added on top
	assign nxt_out = acc_ff + ((level_ff && !ctrl_ff[CTRL_PHASE_SEL]) ?
		{{7{dev_hi_ff}}, dev_hi_ff, dev_lo_ff} : 40'h00_0000_0000);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			div_int_ff <= NDIV_RST;
			div_frac_ff <= NUM_RST;
			div_den_ff <= DEN_RST;
			phase_ff <= 24'h00_0000;
		end else if (clk_en) begin
			div_int_ff <= nxt_out[39:24];
			div_frac_ff <= nxt_out[23:0];
			// Forced value kept until the engine has really stopped
			div_den_ff <= (ctrl_ff[CTRL_RAMP_EN] || state_ff != ST_IDLE) ?
				RAMP_DEN : den_ff;
			phase_ff <= (level_ff && ctrl_ff[CTRL_PHASE_SEL]) ? dev_lo_ff[23:0] : 24'h00_0000;
		end
	end

	// Per-segment charge pump and flag outputs
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cp_alt_ff <= 1'b0;
			lock_acc_ff <= 1'b0;
			flag_ff <= 2'h0;
			running_ff <= 1'b0;
		end else if (clk_en) begin
			cp_alt_ff <= state_ff == ST_RUN && cfg_ff[SEG_LOCK_LSB +: 2] == LOCK_ALT_CP;
			lock_acc_ff <= state_ff == ST_RUN && cfg_ff[SEG_LOCK_LSB +: 2] == LOCK_ACCEL;
			flag_ff <= (state_ff == ST_RUN) ? cfg_ff[SEG_FLAG_LSB +: 2] : 2'h0;
			running_ff <= state_ff != ST_IDLE && state_ff != ST_HOLD;
		end
	end

	// Sticky interrupt status, set wins over clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_stat_ff <= 3'h0;
			irq_ff <= 1'b0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~((do_wr && aw_addr_ff == OFS_IRQ_CLR && wstrb_ff[0]) ?
				wdata_ff[2:0] : 3'h0))
				| {ktrig, clk_en && state_ff == ST_RUN && advance && nxt_seg == 3'h0
					&& ramp_cnt_ff != '0 && pass_ff + 1'b1 == ramp_cnt_ff,
					clk_en && state_ff == ST_RUN && advance && ctrl_ff[CTRL_RAMP_EN]
					&& !restart_ff};
			irq_ff <= |(irq_stat_ff & irq_en_ff);
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign div_int = div_int_ff;
	assign div_frac = div_frac_ff;
	assign div_den = div_den_ff;
	assign phase_offset = phase_ff;
	assign keying_level = level_ff;
	assign cp_alt_current = cp_alt_ff;
	assign lock_accel_active = lock_acc_ff;
	assign ramp_flag = flag_ff;
	assign ramp_running = running_ff;
	assign irq = irq_ff;
endmodule : ramp_fsk_top

// *** bench/ramp_fsk_top_chk.sv ***
`timescale 1ns/10ps
// Port-level checks of the ramp and keying block
module ramp_fsk_chk import ramp_pkg::*; (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] div_int,
	input wire logic [23:0] div_frac,
	input wire logic [24:0] div_den,
	input wire logic cp_alt_current,
	input wire logic lock_accel_active,
	input wire logic ramp_running
);
	// One clock domain, one reset
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	// Divider and controls
	a_reset_values: assert property (disable iff (1'b0) srst |=> div_int == NDIV_RST && div_den == DEN_RST)
		else $error("divider not at reset values");
	a_ramp_den: assert property (ramp_running && $past(ramp_running) |-> div_den == RAMP_DEN)
		else $error("denominator not forced while ramping");
	a_freeze_div: assert property (!clk_en |=> $stable(div_int) && $stable(div_frac))
		else $error("divider moved without a detector cycle");
	a_cp_exclusive: assert property (!(cp_alt_current && lock_accel_active))
		else $error("alternate current and acceleration together");
	// Register bus
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##[0:2] s_axi_rvalid)
		else $error("read answer late");
	a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken before write done");

	// Main scenarios reached
	c_read: cover property ($rose(s_axi_rvalid));
	c_alt_cp: cover property ($rose(cp_alt_current));
	c_accel: cover property ($rose(lock_accel_active));
	c_freeze: cover property (!clk_en);
endmodule : ramp_fsk_chk

bind ramp_fsk_top ramp_fsk_chk u_chk (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
	.s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.div_int(div_int), .div_frac(div_frac), .div_den(div_den), .cp_alt_current(cp_alt_current),
	.lock_accel_active(lock_accel_active), .ramp_running(ramp_running));

// *** bench/div_model.sv ***
`timescale 1ns/10ps
// Modulator side: division on a 2^24 grid, sampled per detector cycle
module div_model (
	input wire logic sys_clk,
	input wire logic clk_en,
	input wire logic clr,
	input wire logic [15:0] div_int,
	input wire logic [23:0] div_frac,
	output logic [39:0] ext_ff,
	output logic [39:0] max_ff,
	output logic [39:0] min_ff
);
	// Integer and fraction as one number; carries land in the integer
	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			ext_ff <= {div_int, div_frac};
		end
	end
	// Extremes of the division since the last clear
	always_ff @(posedge sys_clk) begin
		if (clr) begin
			max_ff <= 40'h00_0000_0000;
			min_ff <= 40'hFF_FFFF_FFFF;
		end else if (clk_en) begin
			if ({div_int, div_frac} > max_ff) max_ff <= {div_int, div_frac};
			if ({div_int, div_frac} < min_ff) min_ff <= {div_int, div_frac};
		end
	end
endmodule : div_model

// *** bench/pll_ramp_fsk_modulator_test.sv ***
`timescale 1ns/10ps
module pll_ramp_fsk_modulator_test import ramp_pkg::*; ;
	logic sys_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, clr = 1'b0, lvl = 1'b0;
	logic aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
	logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
	logic [31:0] w_d = 32'h0000_0000;
	logic [3:0] w_s = 4'h0, pins = 4'h0;
	logic aw_r, w_r, b_v, ar_r, r_v, lvl_o, cp_alt, accel, run, irq;
	logic [1:0] b_resp, r_resp, flag, al;
	logic [31:0] r_d;
	logic [15:0] d_int;
	logic [23:0] d_frac, ph, dev;
	logic [24:0] d_den;
	logic [29:0] inc;
	logic [39:0] ext, ext_max, ext_min, e0;
	logic [65:0] exp_r;
	logic [65:0] rq[$];
	logic [1:0] wq[$];
	int dur[2];
	int n_mismatch = 0, n_compared = 0;

	always #10 sys_clk = ~sys_clk;

	ramp_fsk_top uut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .s_axi_awaddr(aw_a),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(w_s),
		.s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
		.s_axi_bready(b_rdy), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy),
		.io_pin_one(pins[0]), .io_pin_two(pins[1]), .io_pin_three(pins[2]),
		.selectable_output_pin(pins[3]), .div_int(d_int), .div_frac(d_frac), .div_den(d_den),
		.phase_offset(ph), .keying_level(lvl_o), .cp_alt_current(cp_alt),
		.lock_accel_active(accel), .ramp_flag(flag), .ramp_running(run), .irq(irq));

	div_model partner (.sys_clk(sys_clk), .clk_en(clk_en), .clr(clr), .div_int(d_int),
		.div_frac(d_frac), .ext_ff(ext), .max_ff(ext_max), .min_ff(ext_min));

	// Compare and count
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	// Bus write: both channels offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		wq.push_back(er);
		aw_a <= a;
		w_d <= d;
		w_s <= 4'hF;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge sys_clk);
			if (aw_r && !ad) begin
				ad = 1'b1;
				aw_v <= 1'b0;
			end
			if (w_r && !wd) begin
				wd = 1'b1;
				w_v <= 1'b0;
			end
		end
		do @(posedge sys_clk); while (!b_v);
		b_rdy <= 1'b0;
		@(posedge sys_clk); // Idle edge before the next request
	endtask : wr

	// Bus read with masked expectation
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF,
		input logic [1:0] er = RESP_OKAY);
		rq.push_back({er, m, e});
		ar_a <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		do @(posedge sys_clk); while (!ar_r);
		ar_v <= 1'b0;
		do @(posedge sys_clk); while (!r_v);
		r_rdy <= 1'b0;
		@(posedge sys_clk); // Idle edge before the next request
	endtask : rd

	// Each bus answer against the oldest note
	always @(posedge sys_clk) begin
		if (b_v && b_rdy) check("bresp", b_resp, wq.pop_front());
		if (r_v && r_rdy) begin
			exp_r = rq.pop_front();
			check("rresp", r_resp, exp_r[65:64]);
			check("rdata", r_d & exp_r[63:32], exp_r[31:0]);
		end
	end

	// Watchdog
	initial begin
		#1_000_000;
		n_mismatch++;
		stop_test();
	end

	initial begin
		void'($urandom(10));
		dev = 24'($urandom_range(24'hF_FFFF, 24'h1_0000));
		inc = 30'($urandom_range(4095, 16));
		cyc(8);
		srst <= 1'b0;
		cyc(1);
		// Reset values, unmapped place
		rd(OFS_NDIV, 32'h0000_0064);
		rd(OFS_DEN, 32'h0100_0000);
		rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
		wr(8'h38, 32'h0000_0001, RESP_SLVERR);
		// Keying from software and from every pin, phase then frequency
		wr(OFS_DEV_LO, {8'h00, dev});
		wr(OFS_DEV_HI, 32'h0000_0000);
		wr(OFS_IRQ_EN, 32'h0000_0000);
		for (int k = 0; k < 6; k++) begin
			wr(OFS_CTRL, {27'h0, 3'(k % 5), k == 0, 1'h0});
			if (k % 5 == 0) wr(OFS_SW_CMD, 32'h0000_0001);
			else pins[k - 1] <= ~pins[k - 1];
			lvl = ~lvl;
			while (lvl_o !== lvl) @(posedge sys_clk);
			cyc(3);
			check("div", {d_int, d_frac}, {16'h0064, (lvl && k != 0) ? dev : 24'h00_0000});
			check("phase", ph, (lvl && k == 0) ? dev : 24'h00_0000);
			check("irq", irq, 1'h0);
		end
		// Interrupt: masked, enabled, cleared
		rd(OFS_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
		wr(OFS_IRQ_EN, 32'h0000_0004);
		cyc(3);
		check("irq", irq, 1'h1);
		wr(OFS_IRQ_CLR, 32'h0000_0004);
		cyc(3);
		check("irq", irq, 1'h0);
		// Two segments across an integer boundary, looping
		wr(OFS_NUM, 32'h00FF_FFF0);
		wr(OFS_DEN, 32'h0000_0100);
		wr(8'h40, {2'h0, inc});
		wr(8'h44, {6'h00, 2'h1, LOCK_ACCEL, 3'h1, ADV_LENGTH, 1'h0, 16'h0004});
		wr(8'h48, {2'h0, -inc});
		wr(8'h4C, {6'h00, 2'h2, LOCK_ALT_CP, 3'h0, ADV_LENGTH, 1'h1, 16'h0004});
		wr(OFS_CTRL, 32'h0000_0001);
		wr(OFS_NDIV, 32'h0000_0064);
		clr <= 1'h1;
		cyc(1);
		clr <= 1'h0;
		while (flag !== 2'h2) @(posedge sys_clk);
		al = 2'h0;
		for (int s = 1; s < 3; s++) begin
			while (flag !== 2'(s)) @(posedge sys_clk);
			while (flag === 2'(s)) begin
				dur[s - 1]++;
				if (dur[s - 1] == 2) al = al | (s == 1 ? {cp_alt, accel} : {accel, cp_alt});
				@(posedge sys_clk);
			end
		end
		check("den", d_den, RAMP_DEN);
		check("dbl", dur[1] - dur[0], 4);
		check("lock", al, 2'h1);
		check("max", ext_max, 40'h00_64FF_FFF0 + 4 * inc);
		check("min", ext_min, 40'h00_64FF_FFF0);
		// Pass limit, frozen detector, keying on top of the ramp
		wr(OFS_IRQ_EN, 32'h0000_0002);
		wr(OFS_RAMP_CNT, 32'h0000_0002);
		wr(OFS_NDIV, 32'h0000_0064);
		while (irq !== 1'h1) @(posedge sys_clk);
		rd(OFS_STATUS, 32'h0002_0000, 32'hFFFF_0000);
		clk_en <= 1'h0;
		cyc(5);
		clk_en <= 1'h1;
		cyc(2);
		e0 = ext;
		wr(OFS_SW_CMD, 32'h0000_0001);
		lvl = ~lvl;
		while (lvl_o !== lvl) @(posedge sys_clk);
		cyc(3);
		check("keyed", ext - e0, 40'(dev));
		// Segment waiting on trigger A, then released by software
		wr(8'h44, {6'h00, 2'h1, 2'h0, 3'h0, 2'h1, 1'h0, 16'h0004});
		wr(OFS_NDIV, 32'h0000_0064);
		while (flag !== 2'h1) @(posedge sys_clk);
		cyc(12);
		check("held", flag, 2'h1);
		wr(OFS_SW_CMD, 32'h0000_0002);
		cyc(1);
		check("trig_a", flag, 2'h0);
		wr(OFS_CTRL, 32'h0000_0000);
		cyc(3);
		check("run", run, 1'h0);
		check("den", d_den, 25'h000_0100);
		stop_test();
	end
endmodule : pll_ramp_fsk_modulator_test
